// ===== rtl/mato_regs.svh
`ifndef MATO_REGS_SVH
`define MATO_REGS_SVH

// Address geometry
`define MATO_VA_W        32
`define MATO_PA_W        32
`define MATO_PAGE_W      12
`define MATO_VPN_W       (`MATO_VA_W - `MATO_PAGE_W)
`define MATO_PFN_W       (`MATO_PA_W - `MATO_PAGE_W)
`define MATO_IDX_W       3
`define MATO_CCA_W       3

// Coherence algorithm codes held in a translation entry
`define MATO_CCA_UNCACHED  3'h2
`define MATO_CCA_NONCOH    3'h3
`define MATO_CCA_COH_EXCL  3'h4
`define MATO_CCA_COH_EXWR  3'h5
`define MATO_CCA_COH_UPD   3'h6

// Prefetch instruction decode fields
`define MATO_OPC_MSB       31
`define MATO_OPC_LSB       26
`define MATO_FN_MSB        5
`define MATO_FN_LSB        0
`define MATO_OPC_PREFETCH_BASE_OFFSET_OFF  6'h33
`define MATO_OPC_FPX       6'h13
`define MATO_FN_PREFETCH_BASE_OFFSET_IDX   6'h0f

// Outstanding-operation counter
`define MATO_CNT_W         6
`define MATO_CNT_ONE       6'h01

`endif

// ===== rtl/mato_pkg.sv
`include "mato_regs.svh"

package mato_pkg;

  typedef enum logic [2:0] {
    MATO_OP_LOAD    = 3'h0,
    MATO_OP_STORE   = 3'h1,
    MATO_OP_IFETCH  = 3'h2,
    MATO_OP_LINKED  = 3'h3,
    MATO_OP_COND    = 3'h4,
    MATO_OP_PREFETCH_BASE_OFFSET    = 3'h5,
    MATO_OP_BARRIER = 3'h6
  } mato_op_t;

  typedef enum logic [1:0] {
    MATO_AT_UNCACHED = 2'h0,
    MATO_AT_NONCOH   = 2'h1,
    MATO_AT_COHERENT = 2'h2
  } mato_atype_t;

  typedef enum logic [1:0] {
    MATO_PF_NONE   = 2'h0,
    MATO_PF_OFFSET = 2'h1,
    MATO_PF_INDEX  = 2'h2
  } mato_pform_t;

  typedef enum logic [1:0] {
    MATO_ST_RUN   = 2'b00,
    MATO_ST_DRAIN = 2'b01
  } mato_state_t;

  typedef struct packed {
    mato_op_t                op;
    logic [`MATO_VA_W-1:0]   vaddr;
    logic [31:0]             insn;
  } mato_req_t;

  typedef struct packed {
    logic [`MATO_IDX_W-1:0]  index;
    logic                    valid;
    logic [`MATO_VPN_W-1:0]  vpn;
    logic [`MATO_PFN_W-1:0]  pfn;
    logic [`MATO_CCA_W-1:0]  cca;
  } mato_tlb_wr_t;

  typedef struct packed {
    logic                    valid;
    mato_op_t                op;
    logic [`MATO_PA_W-1:0]   paddr;
    logic [`MATO_CCA_W-1:0]  cca;
    mato_atype_t             atype;
    logic                    snoop;
  } mato_acc_t;

endpackage

// ===== rtl/mato_top.sv
// Notes on behaviour
// - Barrier waits for earlier loads and stores
// - Barrier covers only uncached and coherent references
// - Uncached goes straight to memory, no cache
// - Noncoherent uses only local cache and memory
// - Coherent access snoops all coherent cached copies
// - Copy class follows the filling access type
// - Noncoherent copies may or may not be snooped
// - Access type comes from entry coherence code
// - Type selected by virtual page only
// - Multiprocessor build offers three types, else two
// - Same-type accesses observed in program order
// - Linked pair defined only for cached types
// - Coherent variants share one access type
// - Accesses carry their specific coherence code
// - Access type steers fetch, load, store, prefetch
// - Prefetches are hints, fill cache, no state
// - Indexed prefetch decoded from floating-point space
// - Single-processor cached means cached noncoherent
`timescale 1ns/1ns
`default_nettype none
`include "mato_regs.svh"

module mato_top #(
  parameter bit MP_SUPPORT = 1'b1,
  parameter int TLB_N      = 8
) (
  // Clock and reset
  input  wire  logic                  ref_clk_in,
  input  wire  logic                  resetn_in,
  // Request from the load/store pipeline
  input  wire  logic                  req_valid_in,
  input  wire  mato_pkg::mato_req_t   req_in,
  output var   logic                  req_ready_out,
  // Translation entry write
  input  wire  logic                  tlb_wr_in,
  input  wire  mato_pkg::mato_tlb_wr_t tlb_entry_in,
  // Completions of uncached and coherent references
  input  wire  logic                  uc_done_in,
  input  wire  logic                  coh_done_in,
  // Issued accesses
  output var   mato_pkg::mato_acc_t   mem_acc_out,
  output var   mato_pkg::mato_acc_t   cache_acc_out,
  // Status
  output var   logic                  xlate_miss_out,
  output var   logic                  llsc_unspec_out,
  output var   mato_pkg::mato_pform_t prefetch_base_offset_form_out,
  output var   logic                  barrier_busy_out
);

  // Map a coherence code to its access type
  // Unknown codes fall back to uncached: slow, but never incoherent
  function automatic mato_pkg::mato_atype_t cca_to_atype(
    input logic [`MATO_CCA_W-1:0] cca
  );
    mato_pkg::mato_atype_t at;
    at = mato_pkg::MATO_AT_UNCACHED;
    case (cca)
      `MATO_CCA_UNCACHED: at = mato_pkg::MATO_AT_UNCACHED;
      `MATO_CCA_NONCOH:   at = mato_pkg::MATO_AT_NONCOH;
      `MATO_CCA_COH_EXCL,
      `MATO_CCA_COH_EXWR,
      `MATO_CCA_COH_UPD: begin
        // Coherent variants collapse; no coherence without multiprocessor
        at = MP_SUPPORT ? mato_pkg::MATO_AT_COHERENT
                        : mato_pkg::MATO_AT_NONCOH;
      end
      default:            at = mato_pkg::MATO_AT_UNCACHED;
    endcase
    return at;
  endfunction

  // Recognise the two prefetch encodings
  function automatic mato_pkg::mato_pform_t decode_prefetch_base_offset(input logic [31:0] insn);
    mato_pkg::mato_pform_t pf;
    pf = mato_pkg::MATO_PF_NONE;
    if (insn[`MATO_OPC_MSB:`MATO_OPC_LSB] == `MATO_OPC_PREFETCH_BASE_OFFSET_OFF) begin
      pf = mato_pkg::MATO_PF_OFFSET;
    end else if (insn[`MATO_OPC_MSB:`MATO_OPC_LSB] == `MATO_OPC_FPX &&
                 insn[`MATO_FN_MSB:`MATO_FN_LSB] == `MATO_FN_PREFETCH_BASE_OFFSET_IDX) begin
      pf = mato_pkg::MATO_PF_INDEX;
    end
    return pf;
  endfunction

  // Linked load or conditional store; both share the cached-only caveat
  function automatic logic is_llsc(input mato_pkg::mato_op_t op);
    return op == mato_pkg::MATO_OP_LINKED || op == mato_pkg::MATO_OP_COND;
  endfunction

  // Step the outstanding count by one new reference and up to two completions.
  // Both completion kinds may land in the same cycle as a new counted reference,
  // so each is applied on its own rather than folded into one case.
  function automatic logic [`MATO_CNT_W-1:0] cnt_next(
    input logic [`MATO_CNT_W-1:0] cnt,
    input logic                   add,
    input logic                   done_uc,
    input logic                   done_coh
  );
    logic [`MATO_CNT_W-1:0] n;
    n = cnt;
    if (add) begin
      n = n + `MATO_CNT_ONE;
    end
    if (done_uc) begin
      n = n - `MATO_CNT_ONE;
    end
    if (done_coh) begin
      n = n - `MATO_CNT_ONE;
    end
    return n;
  endfunction

  // Translation table state
  logic                   tlb_v_q   [TLB_N];
  logic [`MATO_VPN_W-1:0] tlb_vpn_q [TLB_N];
  logic [`MATO_PFN_W-1:0] tlb_pfn_q [TLB_N];
  logic [`MATO_CCA_W-1:0] tlb_cca_q [TLB_N];
  logic                   tlb_v_d   [TLB_N];
  logic [`MATO_VPN_W-1:0] tlb_vpn_d [TLB_N];
  logic [`MATO_PFN_W-1:0] tlb_pfn_d [TLB_N];
  logic [`MATO_CCA_W-1:0] tlb_cca_d [TLB_N];

  // Translation entry writes
  // A write is seen by a request taken at the following edge
  always_comb begin
    for (int i = 0; i < TLB_N; i++) begin
      tlb_v_d[i]   = tlb_v_q[i];
      tlb_vpn_d[i] = tlb_vpn_q[i];
      tlb_pfn_d[i] = tlb_pfn_q[i];
      tlb_cca_d[i] = tlb_cca_q[i];
      if (tlb_wr_in && tlb_entry_in.index == i[`MATO_IDX_W-1:0]) begin
        tlb_v_d[i]   = tlb_entry_in.valid;
        tlb_vpn_d[i] = tlb_entry_in.vpn;
        tlb_pfn_d[i] = tlb_entry_in.pfn;
        tlb_cca_d[i] = tlb_entry_in.cca;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      // Entries come up invalid, so every page misses until written
      for (int i = 0; i < TLB_N; i++) begin
        tlb_v_q[i]   <= 1'b0;
        tlb_vpn_q[i] <= '0;
        tlb_pfn_q[i] <= '0;
        tlb_cca_q[i] <= `MATO_CCA_UNCACHED;
      end
    end else begin
      for (int i = 0; i < TLB_N; i++) begin
        tlb_v_q[i]   <= tlb_v_d[i];
        tlb_vpn_q[i] <= tlb_vpn_d[i];
        tlb_pfn_q[i] <= tlb_pfn_d[i];
        tlb_cca_q[i] <= tlb_cca_d[i];
      end
    end
  end

  // Lookup by virtual page number only
  // Lowest matching entry wins, so a duplicated page resolves to one code
  logic                   hit;
  logic [`MATO_PFN_W-1:0] hit_pfn;
  logic [`MATO_CCA_W-1:0] hit_cca;

  always_comb begin
    hit     = 1'b0;
    hit_pfn = '0;
    hit_cca = `MATO_CCA_UNCACHED;
    for (int i = 0; i < TLB_N; i++) begin
      if (!hit && tlb_v_q[i] &&
          tlb_vpn_q[i] == req_in.vaddr[`MATO_VA_W-1:`MATO_PAGE_W]) begin
        hit     = 1'b1;
        hit_pfn = tlb_pfn_q[i];
        hit_cca = tlb_cca_q[i];
      end
    end
  end

  // Issue, barrier and outstanding-count state
  mato_pkg::mato_state_t  state_q, state_d;
  logic [`MATO_CNT_W-1:0] cnt_q, cnt_d;
  logic                   ready_q, ready_d;
  mato_pkg::mato_acc_t    mem_q, mem_d;
  mato_pkg::mato_acc_t    cache_q, cache_d;
  logic                   miss_q, miss_d;
  logic                   llsc_q, llsc_d;
  logic                   busy_q, busy_d;
  mato_pkg::mato_pform_t  pform_q, pform_d;

  logic                   take;
  logic                   is_ls;
  logic                   counted;
  mato_pkg::mato_atype_t  at;
  mato_pkg::mato_pform_t  pf;
  mato_pkg::mato_acc_t    acc;

  // Resolve each accepted request by its access type
  // Only one request is taken per cycle and each answer leaves one cycle
  // later, so same-type references reach memory in program order.
  always_comb begin
    take    = req_valid_in && ready_q;
    at      = cca_to_atype(hit_cca);
    pf      = decode_prefetch_base_offset(req_in.insn);
    is_ls   = req_in.op == mato_pkg::MATO_OP_LOAD ||
              req_in.op == mato_pkg::MATO_OP_STORE ||
              is_llsc(req_in.op);
    counted = 1'b0;
    state_d = state_q;
    cnt_d   = cnt_q;
    miss_d  = 1'b0;
    llsc_d  = 1'b0;
    pform_d = mato_pkg::MATO_PF_NONE;
    mem_d   = '0;
    cache_d = '0;
    acc.valid = 1'b1;
    acc.op    = req_in.op;
    acc.paddr = {hit_pfn, req_in.vaddr[`MATO_PAGE_W-1:0]};
    acc.cca   = hit_cca;
    acc.atype = at;
    // Only coherent fills snoop; noncoherent copies are never examined
    acc.snoop = at == mato_pkg::MATO_AT_COHERENT;
    if (take && req_in.op == mato_pkg::MATO_OP_BARRIER) begin
      state_d = mato_pkg::MATO_ST_DRAIN;
    end else if (take && req_in.op == mato_pkg::MATO_OP_PREFETCH_BASE_OFFSET) begin
      // Hint only: unknown encodings, misses and uncached pages drop
      pform_d = pf;
      if (pf != mato_pkg::MATO_PF_NONE && hit &&
          at != mato_pkg::MATO_AT_UNCACHED) begin
        cache_d = acc;
      end
    end else if (take && !hit) begin
      miss_d = 1'b1;
    end else if (take) begin
      // Linked pair outcome is unspecified outside cached pages
      llsc_d = is_llsc(req_in.op) && at == mato_pkg::MATO_AT_UNCACHED;
      if (at == mato_pkg::MATO_AT_UNCACHED) begin
        mem_d = acc;
      end else begin
        cache_d = acc;
      end
      counted = is_ls && at != mato_pkg::MATO_AT_NONCOH;
    end
    // Count outstanding uncached and coherent loads and stores
    cnt_d = cnt_next(cnt_q, counted, uc_done_in, coh_done_in);
    // Drain ends only when nothing earlier is still in flight. A barrier
    // always drains for at least one cycle, even with nothing in flight:
    // one bubble, traded for a single exit test.
    case (state_q)
      mato_pkg::MATO_ST_RUN:   state_d = state_d;
      mato_pkg::MATO_ST_DRAIN: begin
        if (cnt_d == '0) begin
          state_d = mato_pkg::MATO_ST_RUN;
        end
      end
      default:                 state_d = mato_pkg::MATO_ST_RUN;
    endcase
    // Issue stays in order, one per cycle, stalled during a drain
    ready_d = state_d == mato_pkg::MATO_ST_RUN;
    // Busy has its own flip-flop so the pin is never a decode of the state
    busy_d  = state_d == mato_pkg::MATO_ST_DRAIN;
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= mato_pkg::MATO_ST_RUN;
      cnt_q   <= '0;
      ready_q <= 1'b0;
      mem_q   <= '0;
      cache_q <= '0;
      miss_q  <= 1'b0;
      llsc_q  <= 1'b0;
      pform_q <= mato_pkg::MATO_PF_NONE;
      busy_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      ready_q <= ready_d;
      mem_q   <= mem_d;
      cache_q <= cache_d;
      miss_q  <= miss_d;
      llsc_q  <= llsc_d;
      pform_q <= pform_d;
      busy_q  <= busy_d;
    end
  end

  // Outputs straight from flip-flops
  assign req_ready_out    = ready_q;
  assign mem_acc_out      = mem_q;
  assign cache_acc_out    = cache_q;
  assign xlate_miss_out   = miss_q;
  assign llsc_unspec_out  = llsc_q;
  assign prefetch_base_offset_form_out    = pform_q;
  assign barrier_busy_out = busy_q;

endmodule

`default_nettype wire

// ===== dv/mato_chk.sv
`timescale 1ns/1ns
`default_nettype none
module mato_chk #(
  parameter bit MP_SUPPORT = 1'b1
) (
  // Clock and reset
  input wire logic                  ref_clk_in,
  input wire logic                  resetn_in,
  // Requests and issued accesses
  input wire logic                  req_valid_in,
  input wire mato_pkg::mato_req_t   req_in,
  input wire logic                  req_ready_out,
  input wire mato_pkg::mato_acc_t   mem_acc_out,
  input wire mato_pkg::mato_acc_t   cache_acc_out,
  input wire logic                  xlate_miss_out,
  input wire mato_pkg::mato_pform_t prefetch_base_offset_form_out,
  input wire logic                  barrier_busy_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  // Request accepted at this edge
  wire logic taken = req_valid_in && req_ready_out;
  property p_uc;
    mem_acc_out.valid |-> mem_acc_out.atype == 2'h0 && !cache_acc_out.valid;
  endproperty
  a_uc: assert property (p_uc) else $error("memory access not uncached");
  property p_snoop;
    cache_acc_out.valid |-> cache_acc_out.snoop == (cache_acc_out.atype == 2'h2);
  endproperty
  a_snoop: assert property (p_snoop) else $error("snoop does not follow type");
  property p_grp;
    cache_acc_out.valid && cache_acc_out.cca inside {[3'h4:3'h6]} |->
      cache_acc_out.atype == (MP_SUPPORT ? 2'h2 : 2'h1);
  endproperty
  a_grp: assert property (p_grp) else $error("coherent variant mistyped");
  property p_ans;
    taken && req_in.op == 3'h0 |=> mem_acc_out.valid || cache_acc_out.valid || xlate_miss_out;
  endproperty
  a_ans: assert property (p_ans) else $error("load not answered");
  property p_va;
    cache_acc_out.valid |-> cache_acc_out.paddr[11:0] == $past(req_in.vaddr[11:0]);
  endproperty
  a_va: assert property (p_va) else $error("page offset lost");
  property p_busy;
    barrier_busy_out |-> !req_ready_out;
  endproperty
  a_busy: assert property (p_busy) else $error("ready while draining");
  property p_hold;
    barrier_busy_out && $past(barrier_busy_out) |-> !mem_acc_out.valid && !cache_acc_out.valid;
  endproperty
  a_hold: assert property (p_hold) else $error("access issued during drain");
  property p_pfx;
    taken && req_in.op == 3'h5 && req_in.insn[31:26] == 6'h13 && req_in.insn[5:0] == 6'h0f
      |=> prefetch_base_offset_form_out == 2'h2;
  endproperty
  a_pfx: assert property (p_pfx) else $error("indexed prefetch not decoded");
  property p_drain;
    $rose(barrier_busy_out) |-> ##[1:40] !barrier_busy_out;
  endproperty
  a_drain: assert property (p_drain) else $error("drain never ends");
endmodule
bind mato_top mato_chk #(.MP_SUPPORT(MP_SUPPORT)) chk_u (.ref_clk_in, .resetn_in, .req_valid_in,
  .req_in, .req_ready_out,
  .mem_acc_out, .cache_acc_out, .xlate_miss_out, .prefetch_base_offset_form_out, .barrier_busy_out);
`default_nettype wire

// ===== dv/mato_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module mato_mem_model (
  // Clock, reset and pacing
  input  wire logic                clk_in,
  input  wire logic                resetn_in,
  input  wire logic                slow_in,
  // Accesses seen and completions returned
  input  wire mato_pkg::mato_acc_t mem_acc_in,
  input  wire mato_pkg::mato_acc_t cache_acc_in,
  output var  logic                uc_done_out,
  output var  logic                coh_done_out
);
  int         n_uc;
  int         n_coh;
  logic       go;
  logic [2:0] gap_q;
  // Tally counted references, retire at most one of each kind per grant
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      n_uc = 0;
      n_coh = 0;
      gap_q <= 3'h0;
      uc_done_out <= 1'b0;
      coh_done_out <= 1'b0;
    end else begin
      go = !slow_in || gap_q == 3'h0;
      n_uc += int'(mem_acc_in.valid && mem_acc_in.op inside {3'h0, 3'h1, 3'h3, 3'h4});
      n_coh += int'(cache_acc_in.valid && cache_acc_in.snoop
                    && cache_acc_in.op inside {3'h0, 3'h1, 3'h3, 3'h4});
      gap_q <= gap_q + 3'h1;
      uc_done_out <= go && n_uc > 0;
      coh_done_out <= go && n_coh > 0;
      n_uc -= int'(go && n_uc > 0);
      n_coh -= int'(go && n_coh > 0);
    end
  end
endmodule
`default_nettype wire

// ===== dv/mato_bench.sv
`timescale 1ns/1ns
`default_nettype none
module memory_access_type_ordering_bench;
  localparam logic [19:0] PFN = 20'h00abc;
  logic                   ref_clk_in = 1'b0;
  logic                   resetn_in = 1'b0;
  logic                   req_valid_in = 1'b0;
  mato_pkg::mato_req_t    req_in = '0;
  logic                   tlb_wr_in = 1'b0;
  mato_pkg::mato_tlb_wr_t tlb_entry_in = '0;
  logic                   slow = 1'b0;
  wire logic              req_ready_out, uc_done_in, coh_done_in, xlate_miss_out;
  wire logic              llsc_unspec_out, barrier_busy_out;
  mato_pkg::mato_acc_t    mem_acc_out, cache_acc_out, e, np_mem, np_cache;
  mato_pkg::mato_pform_t  prefetch_base_offset_form_out;
  mato_pkg::mato_acc_t    exp_q[$];
  bit                     port_q[$];
  logic [2:0]             cca_tab[6] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  int                     n_errors = 0;
  int                     tests_run = 0;
  mato_top dut_u (.ref_clk_in, .resetn_in, .req_valid_in, .req_in, .req_ready_out, .tlb_wr_in,
    .tlb_entry_in, .uc_done_in, .coh_done_in, .mem_acc_out, .cache_acc_out, .xlate_miss_out,
    .llsc_unspec_out, .prefetch_base_offset_form_out, .barrier_busy_out);
  mato_mem_model far_u (.clk_in(ref_clk_in), .resetn_in, .slow_in(slow), .mem_acc_in(mem_acc_out),
    .cache_acc_in(cache_acc_out), .uc_done_out(uc_done_in), .coh_done_out(coh_done_in));
  // Single-processor build on the same requests; it never sees coherent completions
  mato_top #(.MP_SUPPORT(1'b0)) dut_np_u (.ref_clk_in, .resetn_in, .req_valid_in, .req_in,
    .req_ready_out(), .tlb_wr_in, .tlb_entry_in, .uc_done_in, .coh_done_in(1'b0),
    .mem_acc_out(np_mem), .cache_acc_out(np_cache), .xlate_miss_out(), .llsc_unspec_out(),
    .prefetch_base_offset_form_out(), .barrier_busy_out());
  // Clock
  initial forever #2 ref_clk_in = ~ref_clk_in;
  task automatic check(string what, logic [63:0] exp, logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Entry i maps page 0x10+i onto frame PFN+i, so no location sees two types
  task automatic tlb(int i, logic [2:0] cca);
    tlb_entry_in = '{i[2:0], 1'b1, 20'h10 + i[19:0], PFN + i[19:0], cca};
    tlb_wr_in = 1'b1;
    @(negedge ref_clk_in);
  endtask
  // Hold a request until taken, noting the access it should produce
  task automatic issue(logic [2:0] op, int pg, logic [31:0] insn, logic [2:0] cca);
    logic [11:0] off;
    logic [1:0]  at;
    logic [1:0]  pf;
    logic [3:0]  np_exp;
    logic [3:0]  np_got;
    off = 12'($urandom);
    at = (cca == 3'h3) ? 2'h1 : (cca inside {[3'h4:3'h6]}) ? 2'h2 : 2'h0;
    pf = (insn[31:26] == 6'h33) ? 2'h1 : (insn[31:26] == 6'h13 && insn[5:0] == 6'h0f) ? 2'h2 : 2'h0;
    req_in = '{mato_pkg::mato_op_t'(op), {20'h10 + pg[19:0], off}, insn};
    req_valid_in = 1'b1;
    if (op != 3'h6 && pg < 6 && !(op == 3'h5 && (at == 2'h0 || pf == 2'h0))) begin
      exp_q.push_back('{1'b1, mato_pkg::mato_op_t'(op), {PFN + pg[19:0], off}, cca,
                        mato_pkg::mato_atype_t'(at), at == 2'h2});
      port_q.push_back(at == 2'h0);
    end
    for (int k = 0; k < 100 && req_ready_out !== 1'b1; k++) @(negedge ref_clk_in);
    @(negedge ref_clk_in);
    if (op == 3'h3 || op == 3'h4) check("llsc flag", at == 2'h0, llsc_unspec_out);
    if (op == 3'h5) check("prefetch form", pf, prefetch_base_offset_form_out);
    if (op != 3'h5 && op != 3'h6) check("miss flag", pg > 5, xlate_miss_out);
    np_exp = {1'b1, (at == 2'h0) ? 2'h0 : 2'h1, 1'b0};
    np_got = (at == 2'h0) ? {np_mem.valid, np_mem.atype, np_mem.snoop}
                          : {np_cache.valid, np_cache.atype, np_cache.snoop};
    if (op < 3'h5 && pg < 6 && !slow) check("uniprocessor access", np_exp, np_got);
  endtask
  // Compare each issued access with the oldest note
  always @(negedge ref_clk_in) begin
    if (mem_acc_out.valid === 1'b1 || cache_acc_out.valid === 1'b1) begin
      if (exp_q.size() == 0) check("unexpected access", 0, 1);
      else begin
        e = exp_q.pop_front();
        check("access", e, port_q.pop_front() ? mem_acc_out : cache_acc_out);
      end
    end
  end
  // Watchdog
  initial begin
    #20000;
    n_errors++;
    final_report();
  end
  initial begin
    void'($urandom(32'h2fd6));
    repeat (10) @(negedge ref_clk_in);
    resetn_in = 1'b1;
    for (int i = 0; i < 6; i++) tlb(i, cca_tab[i]);
    tlb_wr_in = 1'b0;
    for (int i = 0; i < 6; i++) for (int o = 0; o < 5; o++) issue(o[2:0], i, $urandom, cca_tab[i]);
    $display("test types done");
    issue(3'h5, 1, {6'h33, 26'($urandom)}, 3'h3);
    issue(3'h5, 2, {6'h13, 20'($urandom), 6'h0f}, 3'h4);
    issue(3'h5, 0, {6'h33, 26'($urandom)}, 3'h2);
    $display("test prefetch done");
    issue(3'h0, 7, $urandom, 3'h2);
    $display("test miss done");
    req_valid_in = 1'b0;
    slow = 1'b1;
    repeat (20) @(negedge ref_clk_in);
    issue(3'h1, 2, $urandom, 3'h4);
    issue(3'h6, 2, $urandom, 3'h4);
    check("busy after coherent store", 1, barrier_busy_out);
    check("ready while draining", 0, req_ready_out);
    issue(3'h0, 1, $urandom, 3'h3);
    issue(3'h1, 1, $urandom, 3'h3);
    issue(3'h6, 1, $urandom, 3'h3);
    // Even an empty drain holds issue for one cycle; after that it must be over
    req_valid_in = 1'b0;
    @(negedge ref_clk_in);
    check("busy after noncoherent store", 0, barrier_busy_out);
    repeat (5) @(negedge ref_clk_in);
    check("notes left", 0, exp_q.size());
    $display("test barrier done");
    final_report();
  end
endmodule
`default_nettype wire
